// ==== core/link_enh_pkg.sv ====
// Constants, field layout and state codes of the link enhancement block
//==============================================================
// Behaviour
// R1: Two-bit start level selects 2K/1.7K/1K/512 bytes.
// R2: After underrun, retry of packet uses store-and-forward.
// R3: Start at level or at whole packet loaded. 16-word FIFO holds 64 bytes, under every level: whole packets only.
// R4: FIFO drained mid-packet flags underrun, packet errored.
// R5: 2K level sends only complete packets.
// R6: Zero retries count forces store-and-forward.
// R7: Reserved bits read zero, writes ignored.
// R8: Bit 10 enables MPEG stamp fix, format 20h.
// R9: Bit 8 enables DV stamp fix, format 00h.
// R10: Bit 7 enables priority arbitration answers.
// R11: Bit 1 tells PHY acceleration is supported.
// R12: Control fields cleared only by global reset.
// R13: Bit 6 unassigned; EEPROM bit 6 sets PHY permission.
package link_enh_pkg;
	//==============================================================
	// Register bus
	localparam int APB_ADDR_W = 8;
	localparam logic [7:0] LEC_OFFSET = 8'h00; // Control register
	localparam logic [7:0] STAT_OFFSET = 8'h04; // Transmit status
	localparam int DATA_W = 32;
	//==============================================================
	// Control register layout
	localparam int THRESH_LSB = 12;
	localparam int MPEG_BIT = 10;
	localparam int DV_BIT = 8;
	localparam int PRIO_BIT = 7;
	localparam int ACCEL_BIT = 1;
	localparam logic [31:0] LEC_WR_MASK = 32'h0000_3582; // Writable bits
	localparam logic [31:0] LEC_RST = 32'h0000_1000; // Level code 01
	localparam logic [1:0] THR_SAF = 2'h0;
	localparam logic [1:0] THR_1K7 = 2'h1;
	localparam logic [1:0] THR_1K = 2'h2;
	localparam logic [1:0] THR_512 = 2'h3;
	localparam logic [11:0] THR_SAF_BYTES = 12'h800;
	localparam logic [11:0] THR_1K7_BYTES = 12'h6CC;
	localparam logic [11:0] THR_1K_BYTES = 12'h400;
	localparam logic [11:0] THR_512_BYTES = 12'h200;
	//==============================================================
	// Status register layout
	localparam int STAT_UNDERRUN = 0; // Sticky, write one to clear
	localparam int STAT_RETRY = 1;
	localparam int STAT_SENDING = 2;
	localparam int STAT_COUNT_LSB = 8;
	//==============================================================
	// Stream formats and EEPROM byte
	localparam int FORMAT_W = 6;
	localparam logic [5:0] FORMAT_MPEG = 6'h20;
	localparam logic [5:0] FORMAT_DV = 6'h00;
	localparam int EEPROM_PHY_BIT = 6;
	//==============================================================
	// Transmit buffer
	localparam int FIFO_WIDTH = 33; // Data word plus last marker
	localparam int FIFO_DEPTH = 16;
	localparam int CNT_W = 5;
	localparam int WORD_SHIFT = 2; // Four bytes per word
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_SEND = 3'b010,
		ST_DROP = 3'b100
	} tx_state_t;
endpackage : link_enh_pkg

// ==== core/tx_fifo_if.sv ====
// Carrier between the control block and its transmit buffer
`timescale 1ns/1ps
interface tx_fifo_if;
	import link_enh_pkg::*;
	logic wr_valid; // Filling side
	logic wr_ready;
	logic [FIFO_WIDTH-1:0] wr_data;
	logic rd_valid; // Draining side
	logic rd_ready;
	logic [FIFO_WIDTH-1:0] rd_data;
	logic [CNT_W-1:0] count; // Words held
	modport buffer(input wr_valid, wr_data, rd_ready,
		output wr_ready, rd_valid, rd_data, count);
	modport user(output wr_valid, wr_data, rd_ready,
		input wr_ready, rd_valid, rd_data, count);
endinterface : tx_fifo_if

// ==== core/tx_fifo.sv ====
// Synchronous transmit FIFO with registered ready
`timescale 1ns/1ps
module tx_fifo #(
	parameter int WIDTH = 33,
	parameter int DEPTH = 16
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	tx_fifo_if.buffer f
);
	import link_enh_pkg::*;
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] FULL = CW'(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH]; // Storage
	logic [PW-1:0] wp, next_wp; // Write pointer
	logic [PW-1:0] rp, next_rp; // Read pointer
	logic [CW-1:0] count, next_count; // Fill level
	logic ready, next_ready; // Registered not-full
	logic do_wr, do_rd;

	//==============================================================
	// Next pointers and fill level
	always_comb begin
		do_wr = f.wr_valid && ready;
		do_rd = f.rd_ready && (count != '0);
		next_wp = do_wr ? PW'(wp + 1'b1) : wp;
		next_rp = do_rd ? PW'(rp + 1'b1) : rp;
		next_count = CW'(count + CW'(do_wr) - CW'(do_rd));
		// Ready is computed ahead so the port comes from a flop
		next_ready = (next_count != FULL);
	end

	//==============================================================
	// State registers and storage
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			wp <= '0;
			rp <= '0;
			count <= '0;
			ready <= 1'b1;
		end else begin
			wp <= next_wp;
			rp <= next_rp;
			count <= next_count;
			ready <= next_ready;
		end
		if (do_wr && rst_n_i) begin
			mem[wp] <= f.wr_data;
		end
	end

	assign f.wr_ready = ready;
	assign f.rd_valid = (count != '0);
	assign f.rd_data = mem[rp];
	assign f.count = CNT_W'(count);
endmodule : tx_fifo

// ==== core/link_enh_ctrl.sv ====
// Link enhancement control register and transmit start logic
//
// The register offsets and register access over APB are this design's own decisions.
`timescale 1ns/1ps
module link_enh_ctrl (
	input wire logic CLOCK_I,
	input wire logic RST_N_I, // Global reset
	input wire logic SOFT_RST_N_I, // Transmit path reset only
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [link_enh_pkg::APB_ADDR_W-1:0] PADDR_I,
	input wire logic [link_enh_pkg::DATA_W-1:0] PWDATA_I,
	input wire logic [3:0] PSTRB_I,
	output logic PREADY_O,
	output logic [link_enh_pkg::DATA_W-1:0] PRDATA_O,
	output logic PSLVERR_O,
	input wire logic IN_VALID_I,
	input wire logic [link_enh_pkg::DATA_W-1:0] IN_DATA_I,
	input wire logic IN_LAST_I,
	output logic IN_READY_O,
	output logic TX_VALID_O,
	output logic [link_enh_pkg::DATA_W-1:0] TX_DATA_O,
	output logic TX_LAST_O,
	output logic TX_ERROR_O,
	input wire logic TX_READY_I,
	input wire logic RETRY_ZERO_I, // Retries register holds zero
	input wire logic [link_enh_pkg::FORMAT_W-1:0] STREAM_FORMAT_CODE_I,
	output logic MPEG_STAMP_APPLY_O,
	output logic DV_STAMP_APPLY_O,
	output logic PRIORITY_ARB_EN_O,
	output logic PHY_ACCEL_NOTIFY_O,
	input wire logic EEPROM_LOAD_I,
	input wire logic [7:0] EEPROM_BYTE_I,
	output logic PHY_PROGRAM_ALLOW_O
);
	import link_enh_pkg::*;

	//==============================================================
	// Helpers
	function automatic logic [11:0] level_bytes(input logic [1:0] c);
		unique case (c)
			THR_SAF: level_bytes = THR_SAF_BYTES;
			THR_1K7: level_bytes = THR_1K7_BYTES;
			THR_1K: level_bytes = THR_1K_BYTES;
			THR_512: level_bytes = THR_512_BYTES;
		endcase
	endfunction : level_bytes

	function automatic logic [31:0] lane_mask(input logic [3:0] s);
		lane_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
	endfunction : lane_mask

	//==============================================================
	// Declarations
	tx_fifo_if txf ();
	logic [31:0] lec, next_lec; // Writable control bits only
	logic phy_allow, next_phy_allow; // Loaded from EEPROM byte
	logic pready, next_pready;
	logic [31:0] prdata, next_prdata;
	logic pslverr, next_pslverr;
	logic setup, acc_wr, hit_lec, hit_stat;
	logic [31:0] wmask;
	tx_state_t st, next_st; // Transmit sequencer
	logic [CNT_W-1:0] pkts, next_pkts; // Whole packets in FIFO
	logic retry, next_retry; // Next packet is a retry
	logic under, next_under; // Sticky underrun flag
	logic tx_valid, next_tx_valid;
	logic [31:0] tx_data, next_tx_data;
	logic tx_last, next_tx_last;
	logic tx_err, next_tx_err;
	logic mpeg_ap, next_mpeg_ap;
	logic dv_ap, next_dv_ap;
	logic saf, slot_free, start, pop, under_ev, wr_last, pop_last;
	logic [11:0] fill_bytes;
	logic dp_rst_n;

	// Path reset: control fields survive it, the datapath does not
	assign dp_rst_n = RST_N_I && SOFT_RST_N_I;

	tx_fifo #(
		.WIDTH(FIFO_WIDTH),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_i(CLOCK_I),
		.rst_n_i(dp_rst_n),
		.f(txf.buffer)
	);

	//==============================================================
	// Register bus next values
	always_comb begin
		setup = PSEL_I && !PENABLE_I;
		acc_wr = PSEL_I && PENABLE_I && pready && PWRITE_I;
		hit_lec = (PADDR_I == LEC_OFFSET);
		hit_stat = (PADDR_I == STAT_OFFSET);
		// Reserved positions never take write data
		wmask = LEC_WR_MASK & lane_mask(PSTRB_I); // R7
		next_lec = lec;
		if (acc_wr && hit_lec) begin
			next_lec = (lec & ~wmask) | (PWDATA_I & wmask); // R1
		end
		next_phy_allow = phy_allow;
		if (EEPROM_LOAD_I) begin
			next_phy_allow = EEPROM_BYTE_I[EEPROM_PHY_BIT]; // R13
		end
		// One wait-free access phase: ready follows setup
		next_pready = setup;
		next_pslverr = setup && !(hit_lec || hit_stat);
		next_prdata = 32'h0000_0000;
		if (setup && !PWRITE_I && hit_lec) begin
			next_prdata = lec & LEC_WR_MASK; // R7 R13
		end else if (setup && !PWRITE_I && hit_stat) begin
			next_prdata[STAT_UNDERRUN] = under;
			next_prdata[STAT_RETRY] = retry;
			next_prdata[STAT_SENDING] = (st == ST_SEND);
			next_prdata[STAT_COUNT_LSB +: CNT_W] = txf.count;
		end
	end

	//==============================================================
	// Register bus flops; only the global reset clears the fields
	always_ff @(posedge CLOCK_I) begin
		if (!RST_N_I) begin
			lec <= LEC_RST; // R12
			phy_allow <= 1'b0;
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			lec <= next_lec;
			phy_allow <= next_phy_allow;
			pready <= next_pready;
			prdata <= next_prdata;
			pslverr <= next_pslverr;
		end
	end

	//==============================================================
	// Transmit sequencer next values
	always_comb begin
		// Store-and-forward on 2K level, on retry, or with no retries
		saf = (lec[THRESH_LSB +: 2] == THR_SAF) || retry
			|| RETRY_ZERO_I; // R2 R5 R6
		fill_bytes = 12'({txf.count, 2'b00});
		slot_free = !tx_valid || TX_READY_I;
		wr_last = txf.wr_valid && txf.wr_ready && IN_LAST_I;
		start = txf.rd_valid && ((pkts != '0)
			|| (!saf && fill_bytes >= level_bytes(lec[THRESH_LSB +: 2])));
		next_st = st;
		pop = 1'b0;
		under_ev = 1'b0;
		next_tx_valid = tx_valid && !TX_READY_I;
		next_tx_data = tx_data;
		next_tx_last = tx_last;
		next_tx_err = 1'b0;
		next_retry = retry;
		unique case (st)
			ST_IDLE: begin
				if (start) begin
					next_st = ST_SEND; // R3 R5
				end
			end
			ST_SEND: begin
				if (slot_free && txf.rd_valid) begin
					pop = 1'b1;
					next_tx_valid = 1'b1;
					next_tx_data = txf.rd_data[31:0];
					next_tx_last = txf.rd_data[32];
					if (txf.rd_data[32]) begin
						next_st = ST_IDLE;
						next_retry = 1'b0; // Retried packet went out
					end
				end else if (slot_free && pkts == '0) begin
					// Buffer ran dry before the packet end arrived
					under_ev = 1'b1; // R4
					next_tx_err = 1'b1; // R4
					next_retry = 1'b1; // R2
					next_st = ST_DROP;
				end
			end
			ST_DROP: begin
				// The rest of the broken packet is thrown away
				if (txf.rd_valid) begin
					pop = 1'b1;
					if (txf.rd_data[32]) begin
						next_st = ST_IDLE;
					end
				end
			end
		endcase
		pop_last = pop && txf.rd_data[32];
		next_pkts = CNT_W'(pkts + CNT_W'(wr_last) - CNT_W'(pop_last));
		// A new underrun wins over a clear in the same cycle
		next_under = under_ev || (under && !(acc_wr && hit_stat
			&& PSTRB_I[0] && PWDATA_I[STAT_UNDERRUN]));
		next_mpeg_ap = lec[MPEG_BIT]
			&& (STREAM_FORMAT_CODE_I == FORMAT_MPEG); // R8
		next_dv_ap = lec[DV_BIT]
			&& (STREAM_FORMAT_CODE_I == FORMAT_DV); // R9
		txf.rd_ready = pop;
	end

	assign txf.wr_valid = IN_VALID_I;
	assign txf.wr_data = {IN_LAST_I, IN_DATA_I};

	//==============================================================
	// Transmit sequencer flops
	always_ff @(posedge CLOCK_I) begin
		if (!dp_rst_n) begin
			st <= ST_IDLE;
			pkts <= '0;
			retry <= 1'b0;
			under <= 1'b0;
			tx_valid <= 1'b0;
			tx_data <= 32'h0000_0000;
			tx_last <= 1'b0;
			tx_err <= 1'b0;
			mpeg_ap <= 1'b0;
			dv_ap <= 1'b0;
		end else begin
			st <= next_st;
			pkts <= next_pkts;
			retry <= next_retry;
			under <= next_under;
			tx_valid <= next_tx_valid;
			tx_data <= next_tx_data;
			tx_last <= next_tx_last;
			tx_err <= next_tx_err;
			mpeg_ap <= next_mpeg_ap;
			dv_ap <= next_dv_ap;
		end
	end

	//==============================================================
	// Outputs
	assign PREADY_O = pready;
	assign PRDATA_O = prdata;
	assign PSLVERR_O = pslverr;
	assign IN_READY_O = txf.wr_ready;
	assign TX_VALID_O = tx_valid;
	assign TX_DATA_O = tx_data;
	assign TX_LAST_O = tx_last;
	assign TX_ERROR_O = tx_err;
	assign MPEG_STAMP_APPLY_O = mpeg_ap;
	assign DV_STAMP_APPLY_O = dv_ap;
	assign PRIORITY_ARB_EN_O = lec[PRIO_BIT]; // R10
	assign PHY_ACCEL_NOTIFY_O = lec[ACCEL_BIT]; // R11
	assign PHY_PROGRAM_ALLOW_O = phy_allow;

	//==============================================================
	// Checks
	default clocking cb @(posedge CLOCK_I); endclocking
	default disable iff (!RST_N_I);
	property p_level_reset;
		!$past(RST_N_I) |-> lec[THRESH_LSB +: 2] == THR_1K7;
	endproperty
	a_level_reset: assert property (p_level_reset) // R1
		else $error("start level not 01 after reset");
	property p_retry_saf;
		SOFT_RST_N_I && tx_err ##1 SOFT_RST_N_I && st == ST_IDLE
			&& pkts == '0 |=> st != ST_SEND;
	endproperty
	a_retry_saf: assert property (p_retry_saf) // R2
		else $error("retry started before whole packet held");
	property p_start_level;
		SOFT_RST_N_I && st == ST_IDLE && txf.rd_valid && !saf
			&& fill_bytes >= level_bytes(lec[THRESH_LSB +: 2])
			##1 SOFT_RST_N_I |-> st == ST_SEND;
	endproperty
	a_start_level: assert property (p_start_level) // R3
		else $error("no start at start level");
	property p_underrun;
		SOFT_RST_N_I && st == ST_SEND && !txf.rd_valid && pkts == '0
			&& slot_free ##1 SOFT_RST_N_I |-> TX_ERROR_O && under
			##1 !TX_ERROR_O;
	endproperty
	a_underrun: assert property (p_underrun) // R4
		else $error("underrun not flagged for one cycle");
	property p_saf_hold;
		SOFT_RST_N_I && st == ST_IDLE && saf && pkts == '0
			|=> st != ST_SEND;
	endproperty
	a_saf_hold: assert property (p_saf_hold) // R5 R6
		else $error("store-and-forward sent partial packet");
	property p_rsvd_zero;
		PREADY_O |-> (PRDATA_O & ~LEC_WR_MASK) == 32'h0000_0000
			|| $past(hit_stat);
	endproperty
	a_rsvd_zero: assert property (p_rsvd_zero) // R7
		else $error("reserved control bit read as one");
	property p_mpeg;
		SOFT_RST_N_I && lec[MPEG_BIT] && STREAM_FORMAT_CODE_I == FORMAT_MPEG
			##1 SOFT_RST_N_I |-> MPEG_STAMP_APPLY_O;
	endproperty
	a_mpeg: assert property (p_mpeg) // R8
		else $error("MPEG stamp fix not applied");
	property p_dv;
		SOFT_RST_N_I && STREAM_FORMAT_CODE_I != FORMAT_DV
			##1 SOFT_RST_N_I |-> !DV_STAMP_APPLY_O;
	endproperty
	a_dv: assert property (p_dv) // R9
		else $error("DV stamp fix on wrong format");
	property p_prio;
		acc_wr && hit_lec && PSTRB_I[0] |=> PRIORITY_ARB_EN_O
			== $past(PWDATA_I[PRIO_BIT]);
	endproperty
	a_prio: assert property (p_prio) // R10
		else $error("priority enable did not follow write");
	property p_accel;
		acc_wr && hit_lec && PSTRB_I[0] |=> PHY_ACCEL_NOTIFY_O
			== $past(PWDATA_I[ACCEL_BIT]);
	endproperty
	a_accel: assert property (p_accel) // R11
		else $error("acceleration notice did not follow write");
	property p_keep;
		!(acc_wr && hit_lec) |=> $stable(lec);
	endproperty
	a_keep: assert property (p_keep) // R12
		else $error("control field changed without a write");
	property p_phy_allow;
		EEPROM_LOAD_I |=> PHY_PROGRAM_ALLOW_O
			== $past(EEPROM_BYTE_I[EEPROM_PHY_BIT]);
	endproperty
	a_phy_allow: assert property (p_phy_allow) // R13
		else $error("PHY permission not loaded from EEPROM");
	property p_c_packet;
		TX_VALID_O && TX_READY_I && TX_LAST_O;
	endproperty
	c_packet: cover property (p_c_packet);
	property p_c_underrun;
		TX_ERROR_O ##[1:200] TX_VALID_O && TX_LAST_O && retry;
	endproperty
	c_underrun: cover property (p_c_underrun);
	// Whole packet start with store-and-forward in force
	property p_c_saf;
		st == ST_IDLE && saf && pkts != '0 ##1 st == ST_SEND;
	endproperty
	c_saf: cover property (p_c_saf);
endmodule : link_enh_ctrl

// ==== tb/phy_sink_model.sv ====
// Far-side model that takes transmit words like the PHY side would
`timescale 1ns/1ps
module phy_sink_model (
	input wire logic clk_i,
	input wire logic stall_i, // Hold ready low while set
	input wire logic slow_i, // Accept only every other cycle
	input wire logic tx_valid_i,
	input wire logic [31:0] tx_data_i,
	input wire logic tx_last_i,
	output logic tx_ready_o,
	output logic got_o, // One word was taken on the previous edge
	output logic [31:0] got_data_o,
	output logic got_last_o
);
	//==============================================================
	// Ready pattern and capture
	logic phase = 1'b0; // Toggles each cycle for the slow pattern
	initial begin
		tx_ready_o = 1'b0;
		got_o = 1'b0;
		got_data_o = 32'h0000_0000;
		got_last_o = 1'b0;
	end
	// Ready moves only after an edge; a word counts at the edge it meets
	always @(posedge clk_i) begin
		phase <= ~phase;
		tx_ready_o <= ~stall_i & (~slow_i | phase);
		got_o <= tx_valid_i & tx_ready_o;
		got_data_o <= tx_data_i;
		got_last_o <= tx_last_i;
	end
endmodule : phy_sink_model

// ==== tb/async_tx_threshold_link_enhance_ctrl_test.sv ====
// Self-checking bench for the link enhancement control block
`timescale 1ns/1ps
module async_tx_threshold_link_enhance_ctrl_test;
	import link_enh_pkg::*;
	//==============================================================
	// Stimulus and observed signals
	logic clk = 1'b0;
	logic rst_n = 1'b0; // Global reset, active low
	logic soft_rst_n = 1'b1; // Transmit path reset, active low
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [3:0] pstrb = 4'hF;
	logic pready, pslverr, in_ready, tx_valid, tx_last, tx_error, tx_ready;
	logic [31:0] prdata, tx_data, got_data;
	logic in_valid = 1'b0;
	logic [31:0] in_data = 32'h0000_0000;
	logic in_last = 1'b0;
	logic retry_zero = 1'b0; // Retries register holds zero
	logic [5:0] fcode = 6'h00; // Stream format code of the transmit stream
	logic mpeg_apply, dv_apply, prio_en, accel_en, prog_allow, got, got_last;
	logic ee_load = 1'b0;
	logic [7:0] ee_byte = 8'h00;
	logic stall = 1'b0; // Far side refuses words
	logic slow = 1'b0; // Far side takes every other cycle
	logic pkt_open = 1'b0; // A packet is part way into the buffer
	logic hold_check = 1'b1; // Off while one packet drains behind another
	logic [32:0] exp_q[$]; // Words in the order they must leave
	logic [32:0] exp_w;
	int err_count = 0;
	int n_tests = 0;
	always #5 clk = ~clk;
	link_enh_ctrl link_enh_ctrl_i (.CLOCK_I(clk), .RST_N_I(rst_n),
		.SOFT_RST_N_I(soft_rst_n), .PSEL_I(psel), .PENABLE_I(penable),
		.PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
		.PSTRB_I(pstrb), .PREADY_O(pready), .PRDATA_O(prdata),
		.PSLVERR_O(pslverr), .IN_VALID_I(in_valid), .IN_DATA_I(in_data),
		.IN_LAST_I(in_last), .IN_READY_O(in_ready), .TX_VALID_O(tx_valid),
		.TX_DATA_O(tx_data), .TX_LAST_O(tx_last), .TX_ERROR_O(tx_error),
		.TX_READY_I(tx_ready), .RETRY_ZERO_I(retry_zero),
		.STREAM_FORMAT_CODE_I(fcode), .MPEG_STAMP_APPLY_O(mpeg_apply),
		.DV_STAMP_APPLY_O(dv_apply), .PRIORITY_ARB_EN_O(prio_en),
		.PHY_ACCEL_NOTIFY_O(accel_en), .EEPROM_LOAD_I(ee_load),
		.EEPROM_BYTE_I(ee_byte), .PHY_PROGRAM_ALLOW_O(prog_allow));
	phy_sink_model phy_sink_model_i (.clk_i(clk), .stall_i(stall),
		.slow_i(slow), .tx_valid_i(tx_valid), .tx_data_i(tx_data),
		.tx_last_i(tx_last), .tx_ready_o(tx_ready), .got_o(got),
		.got_data_o(got_data), .got_last_o(got_last));
	//==============================================================
	// Compare and verdict
	task automatic cmp32(input string what, input logic [31:0] exp,
		input logic [31:0] seen);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : cmp32
	task automatic cmp1(input string what, input logic exp, input logic seen);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value %s expected %b seen %b", what, exp, seen);
		end
	endtask : cmp1
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : give_verdict
	//==============================================================
	// Bus and stream drivers, all entered just after a rising edge
	// One transfer; the idle edge at the end keeps strobes single per step
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d, input logic [3:0] s,
		output logic [31:0] q, output logic e);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		cmp1("pready", 1'b1, pready);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb
	// Offer one word; a refused word stays on the bus for a later call
	task automatic push(input logic [31:0] d, input logic last,
		input int lim, output logic ok);
		int n;
		in_valid <= 1'b1;
		in_data <= d;
		in_last <= last;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (in_ready !== 1'b1 && n < lim);
		ok = (in_ready === 1'b1);
		if (ok) begin
			exp_q.push_back({last, d});
			pkt_open <= ~last;
		end
	endtask : push
	// Bounded wait until every offered word has reached the far side
	task automatic drain(input int lim);
		int n;
		n = 0;
		while (exp_q.size() != 0 && n < lim) begin
			@(posedge clk);
			n++;
		end
		cmp1("drained", 1'b1, exp_q.size() == 0);
	endtask : drain
	// Registered outputs get three edges to follow their cause
	task automatic settle;
		repeat (3) @(posedge clk);
	endtask : settle
	function automatic logic [31:0] wd(input int p, input int i);
		return {16'hC0DE, 8'(p), 8'(i)};
	endfunction : wd
	//==============================================================
	// Scoreboard: order, last marker, and no start before packet end
	always @(posedge clk) begin
		if (got === 1'b1) begin
			if (exp_q.size() == 0) begin
				cmp1("stray word", 1'b0, 1'b1);
			end else begin
				exp_w = exp_q.pop_front();
				cmp32("tx word", exp_w[31:0], got_data);
				cmp1("tx last", exp_w[32], got_last);
			end
		end
		if (tx_valid === 1'b1 && hold_check === 1'b1) begin
			cmp1("early start", 1'b0, pkt_open);
		end
		// Whole packets only, so no underrun may ever be flagged
		if (rst_n === 1'b1 && tx_error !== 1'b0) begin
			cmp1("tx error", 1'b0, tx_error);
		end
	end
	// Cuts a hang short; the tests need a few hundred cycles
	initial begin
		repeat (30000) @(posedge clk);
		err_count++;
		give_verdict();
	end
	//==============================================================
	// Test sequence
	initial begin
		logic [31:0] rd;
		logic er;
		logic ok;
		logic [1:0] lvl;
		int i;
		int j;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		apb(1'b0, LEC_OFFSET, 32'h0, 4'hF, rd, er);
		cmp32("ctrl reset", 32'h0000_1000, rd);
		cmp1("allow reset", 1'b0, prog_allow);
		// Lane 0 alone must leave the level field untouched
		apb(1'b1, LEC_OFFSET, 32'hFFFF_FFFF, 4'h1, rd, er);
		apb(1'b0, LEC_OFFSET, 32'h0, 4'hF, rd, er);
		cmp32("ctrl lane0", 32'h0000_1082, rd);
		apb(1'b1, LEC_OFFSET, 32'hFFFF_FFFF, 4'hF, rd, er);
		apb(1'b0, LEC_OFFSET, 32'h0, 4'hF, rd, er);
		cmp32("ctrl all", 32'h0000_3582, rd);
		settle();
		cmp1("priority", 1'b1, prio_en);
		cmp1("accel", 1'b1, accel_en);
		// Each enable fires only for its own format code
		for (j = 0; j < 3; j++) begin
			fcode <= (j == 0) ? 6'h20 : 6'(j - 1);
			settle();
			cmp1("mpeg stamp", j == 0, mpeg_apply);
			cmp1("dv stamp", j == 1, dv_apply);
		end
		apb(1'b1, LEC_OFFSET, 32'h0000_3082, 4'hF, rd, er);
		fcode <= 6'h20;
		settle();
		cmp1("mpeg off", 1'b0, mpeg_apply);
		fcode <= 6'h00;
		settle();
		cmp1("dv off", 1'b0, dv_apply);
		ee_byte <= 8'h40;
		ee_load <= 1'b1;
		@(posedge clk);
		ee_load <= 1'b0;
		settle();
		cmp1("allow set", 1'b1, prog_allow);
		// Unmapped place: refused, and the control word is kept
		apb(1'b1, 8'h08, 32'hFFFF_FFFF, 4'hF, rd, er);
		cmp1("slverr wr", 1'b1, er);
		apb(1'b0, 8'h08, 32'h0, 4'hF, rd, er);
		cmp1("slverr rd", 1'b1, er);
		cmp32("unmapped", 32'h0, rd);
		soft_rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		soft_rst_n <= 1'b1;
		apb(1'b0, LEC_OFFSET, 32'h0, 4'hF, rd, er);
		cmp32("ctrl soft", 32'h0000_3082, rd);
		cmp1("allow soft", 1'b1, prog_allow);
		ee_byte <= 8'hBF;
		ee_load <= 1'b1;
		@(posedge clk);
		ee_load <= 1'b0;
		settle();
		cmp1("allow clear", 1'b0, prog_allow);
		// Every level code, then a zero retry count over the 512 level
		for (j = 0; j < 5; j++) begin
			lvl = 2'(j) | {2{j == 4}};
			retry_zero <= (j == 4);
			slow <= j[0];
			apb(1'b1, LEC_OFFSET, {18'h0, lvl, 12'h082}, 4'hF, rd, er);
			for (i = 0; i < 3; i++) begin
				push(wd(j, i), i == 2, 50, ok);
			end
			in_valid <= 1'b0;
			drain(300);
		end
		// Fill until refused while the far side stalls, then drain
		retry_zero <= 1'b0;
		slow <= 1'b0;
		stall <= 1'b1;
		hold_check <= 1'b0;
		for (i = 0; i < 16; i++) begin
			push(wd(8, i), i == 15, 50, ok);
		end
		j = 0;
		ok = 1'b1;
		while (ok && j < 6) begin
			push(wd(9, j), j == 5, 20, ok);
			if (ok) begin
				j++;
			end
		end
		cmp1("refused", 1'b0, ok);
		apb(1'b0, STAT_OFFSET, 32'h0, 4'hF, rd, er);
		cmp32("words held", 32'h0000_0010, 32'(rd[STAT_COUNT_LSB +: CNT_W]));
		cmp1("sending", 1'b1, rd[STAT_SENDING]);
		stall <= 1'b0;
		while (j < 6) begin
			push(wd(9, j), j == 5, 200, ok);
			j++;
		end
		in_valid <= 1'b0;
		drain(400);
		apb(1'b0, STAT_OFFSET, 32'h0, 4'hF, rd, er);
		cmp32("words left", 32'h0000_0000, 32'(rd[STAT_COUNT_LSB +: CNT_W]));
		cmp1("underrun flag", 1'b0, rd[STAT_UNDERRUN]);
		cmp1("retry mode", 1'b0, rd[STAT_RETRY]);
		// Global reset in mid-run restores the defaults
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		apb(1'b0, LEC_OFFSET, 32'h0, 4'hF, rd, er);
		cmp32("ctrl again", 32'h0000_1000, rd);
		cmp1("priority off", 1'b0, prio_en);
		cmp1("accel off", 1'b0, accel_en);
		give_verdict();
	end
endmodule : async_tx_threshold_link_enhance_ctrl_test
